/* File: design/acrp_pkg.sv */
package acrp_pkg;
  // Register map of the serial configuration port (byte addresses).
  localparam logic [7:0] ADDR_CLOCK_INPUT_OPTIONS  = 8'h2a;
  localparam logic [7:0] ADDR_SUPPLY_NOISE_CONTROL = 8'h2b;
  localparam logic [7:0] ADDR_REF_CAPTURE_POS      = 8'h2c;
  localparam logic [7:0] ADDR_FULL_SCALE_RANGE     = 8'h30;
  localparam logic [7:0] ADDR_POWER_MODE_FIRST     = 8'h37;
  localparam logic [7:0] ADDR_CLOCK_CONTROL_ZERO   = 8'h29;

  // Reset values.
  localparam logic [7:0]  RST_CLOCK_INPUT_OPTIONS  = 8'h00;
  localparam logic [7:0]  RST_SUPPLY_NOISE_CONTROL = 8'h10;
  localparam logic [23:0] RST_REF_CAPTURE_POS      = 24'h000000;
  localparam logic [15:0] RST_FULL_SCALE_RANGE     = 16'ha000;
  localparam logic [7:0]  RST_POWER_MODE_FIRST     = 8'h4b;
  localparam logic [7:0]  RST_CLOCK_CONTROL_ZERO   = 8'h80;

  // Field positions.
  localparam int BIT_REF_POLARITY_INVERT = 0;
  localparam int BIT_REF_INPUT_PECL      = 1;
  localparam int BIT_CLK_INPUT_PECL      = 2;
  localparam int BIT_CLOCK_SUPPLY_QUIET  = 0;
  localparam int BIT_ANALOG_SUPPLY_QUIET = 2;
  localparam int REF_DELAY_MSB           = 3;

  // Power mode codes.
  localparam logic [7:0] POWER_CODE_LOW  = 8'h46;
  localparam logic [7:0] POWER_CODE_HIGH = 8'h4b;

  // Full-scale code figures.
  localparam logic [15:0] FULL_SCALE_MIN_GOOD = 16'h2000;
  localparam logic [15:0] FULL_SCALE_MAX      = 16'hffff;

  typedef enum logic [1:0] {
    ACRP_IDLE  = 2'b00,
    ACRP_WRITE = 2'b01,
    ACRP_READ  = 2'b11
  } acrp_access_t;
endpackage

/* File: design/acrp_ref_align.sv */
module acrp_ref_align
  import acrp_pkg::*;
(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // Reference input and controls.
  input  wire logic        i_ref_raw,
  input  wire logic        i_invert,
  input  wire logic [3:0]  i_delay_choice,
  input  wire logic        i_position_valid,
  input  wire logic [23:0] i_position,
  // Results.
  output logic             o_ref_aligned,
  output logic [23:0]      o_position
);
  logic [15:0] tap;

  // The selected delay tap of the (optionally inverted) reference feeds alignment.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tap <= 16'h0000;
    end else begin
      tap <= {tap[14:0], i_ref_raw ^ i_invert};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ref_aligned <= 1'b0;
    end else begin
      o_ref_aligned <= tap[i_delay_choice];
    end
  end

  // The edge position word is captured from the detector when it reports.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_position <= RST_REF_CAPTURE_POS;
    end else if (i_position_valid) begin
      o_position <= i_position;
    end
  end
endmodule

/* File: design/acrp_power_mode.sv */
module acrp_power_mode
  import acrp_pkg::*;
(
  input  wire logic [7:0] i_code,
  output logic            o_low_power,
  output logic            o_high_perf,
  output logic            o_code_reserved
);
  always_comb begin
    o_low_power     = (i_code == POWER_CODE_LOW);
    o_high_perf     = (i_code == POWER_CODE_HIGH);
    o_code_reserved = !(o_low_power || o_high_perf);
  end
endmodule

/* File: design/acrp_regs.sv */
// Operation
// RULE1: Polarity bit inverts alignment reference.
// RULE2: Read-only 24-bit reference edge position word.
// RULE3: Software picks delay from position word.
// RULE4: Delay field bits 3:0 selects sampling delay.
// RULE5: Full-scale code sets range, reset a000.
// RULE6: Software keeps full-scale code at least 2000.
// RULE7: Power code 46 low, 4b high performance.
// RULE8: Low power only at or below 1 GSPS.
// RULE9: Only the two power codes written.
// RULE10: Write all four power registers together.
// RULE11: Calibrate after any power mode change.
// RULE12: Clear calibration and link enables first.
// RULE13: Reserved fields written with default values.
// RULE14: Clock input bit 2 selects PECL.
// RULE15: Reference input bit 1 selects PECL.
// RULE16: Bit 2 quiets analog core supply.
// RULE17: Bit 0 quiets clock circuit supply.
// RULE18: Position word reads harmless, writes ignored.
module acrp_regs
  import acrp_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLK,
  input  wire logic        I_ARST_N,
  // Configuration port, one byte per access.
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  input  wire logic [7:0]  I_ADDR,
  input  wire logic [7:0]  I_WDATA,
  output logic      [7:0]  O_RDATA,
  output logic             O_RVALID,
  // Alignment reference.
  input  wire logic        I_REF_RAW,
  input  wire logic        I_POS_VALID,
  input  wire logic [23:0] I_POS,
  output logic             O_REF_ALIGNED,
  // Analog controls.
  output logic             O_CLOCK_INPUT_PECL_MODE,
  output logic             O_REFERENCE_INPUT_PECL_MODE,
  output logic             O_ANALOG_SUPPLY_QUIETING,
  output logic             O_CLOCK_SUPPLY_QUIETING,
  output logic      [15:0] O_FULL_SCALE_CODE,
  output logic             O_LOW_POWER,
  output logic             O_HIGH_PERF,
  output logic             O_POWER_CODE_RESERVED
);
  import acrp_pkg::*;

  logic [7:0]  clock_control_zero;
  logic [7:0]  clock_input_options;
  logic [7:0]  supply_noise_control;
  logic [15:0] full_scale_range;
  logic [7:0]  power_mode_select_first;
  logic [23:0] reference_edge_position;
  logic [7:0]  next_rdata;

  // Wide registers are reached a byte at a time, low byte at the base address.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] base,
                               input logic [7:0] idx);
    hit = (a == 8'(base + idx));
  endfunction

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      clock_control_zero <= RST_CLOCK_CONTROL_ZERO;
    end else if (I_WR && hit(I_ADDR, ADDR_CLOCK_CONTROL_ZERO, 8'h00)) begin
      clock_control_zero <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      clock_input_options <= RST_CLOCK_INPUT_OPTIONS;
    end else if (I_WR && hit(I_ADDR, ADDR_CLOCK_INPUT_OPTIONS, 8'h00)) begin
      clock_input_options <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      supply_noise_control <= RST_SUPPLY_NOISE_CONTROL;
    end else if (I_WR && hit(I_ADDR, ADDR_SUPPLY_NOISE_CONTROL, 8'h00)) begin
      supply_noise_control <= I_WDATA;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      full_scale_range <= RST_FULL_SCALE_RANGE;
    end else if (I_WR && hit(I_ADDR, ADDR_FULL_SCALE_RANGE, 8'h00)) begin
      full_scale_range[7:0] <= I_WDATA; // RULE5
    end else if (I_WR && hit(I_ADDR, ADDR_FULL_SCALE_RANGE, 8'h01)) begin
      full_scale_range[15:8] <= I_WDATA; // RULE5
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      power_mode_select_first <= RST_POWER_MODE_FIRST;
    end else if (I_WR && hit(I_ADDR, ADDR_POWER_MODE_FIRST, 8'h00)) begin
      power_mode_select_first <= I_WDATA;
    end
  end

  acrp_ref_align u_align (
    .i_clk            (I_CLK),
    .i_arst_n         (I_ARST_N),
    .i_ref_raw        (I_REF_RAW),
    .i_invert         (clock_input_options[BIT_REF_POLARITY_INVERT]), // RULE1
    .i_delay_choice   (clock_control_zero[REF_DELAY_MSB:0]), // RULE4
    .i_position_valid (I_POS_VALID),
    .i_position       (I_POS),
    .o_ref_aligned    (O_REF_ALIGNED),
    .o_position       (reference_edge_position)
  );

  acrp_power_mode u_power (
    .i_code          (power_mode_select_first), // RULE7
    .o_low_power     (O_LOW_POWER),
    .o_high_perf     (O_HIGH_PERF),
    .o_code_reserved (O_POWER_CODE_RESERVED)
  );

  // The position word has no write decode at all and reads change nothing.
  always_comb begin
    next_rdata = 8'h00;
    if (hit(I_ADDR, ADDR_CLOCK_CONTROL_ZERO, 8'h00)) begin
      next_rdata = clock_control_zero;
    end else if (hit(I_ADDR, ADDR_CLOCK_INPUT_OPTIONS, 8'h00)) begin
      next_rdata = clock_input_options;
    end else if (hit(I_ADDR, ADDR_SUPPLY_NOISE_CONTROL, 8'h00)) begin
      next_rdata = supply_noise_control;
    end else if (hit(I_ADDR, ADDR_REF_CAPTURE_POS, 8'h00)) begin
      next_rdata = reference_edge_position[7:0]; // RULE2 RULE18
    end else if (hit(I_ADDR, ADDR_REF_CAPTURE_POS, 8'h01)) begin
      next_rdata = reference_edge_position[15:8]; // RULE2
    end else if (hit(I_ADDR, ADDR_REF_CAPTURE_POS, 8'h02)) begin
      next_rdata = reference_edge_position[23:16]; // RULE2
    end else if (hit(I_ADDR, ADDR_FULL_SCALE_RANGE, 8'h00)) begin
      next_rdata = full_scale_range[7:0];
    end else if (hit(I_ADDR, ADDR_FULL_SCALE_RANGE, 8'h01)) begin
      next_rdata = full_scale_range[15:8];
    end else if (hit(I_ADDR, ADDR_POWER_MODE_FIRST, 8'h00)) begin
      next_rdata = power_mode_select_first;
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA  <= 8'h00;
      O_RVALID <= 1'b0;
    end else begin
      O_RVALID <= I_RD;
      if (I_RD) begin
        O_RDATA <= next_rdata;
      end
    end
  end

  always_comb begin
    O_CLOCK_INPUT_PECL_MODE     = clock_input_options[BIT_CLK_INPUT_PECL]; // RULE14
    O_REFERENCE_INPUT_PECL_MODE = clock_input_options[BIT_REF_INPUT_PECL]; // RULE15
    O_ANALOG_SUPPLY_QUIETING    = supply_noise_control[BIT_ANALOG_SUPPLY_QUIET]; // RULE16
    O_CLOCK_SUPPLY_QUIETING     = supply_noise_control[BIT_CLOCK_SUPPLY_QUIET]; // RULE17
    O_FULL_SCALE_CODE           = full_scale_range; // RULE5
  end
endmodule

/* File: bench/acrp_regs_properties.sv */
module acrp_regs_properties (
  input wire logic        I_CLK,
  input wire logic        I_ARST_N,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [7:0]  I_ADDR,
  input wire logic [7:0]  I_WDATA,
  input wire logic [7:0]  O_RDATA,
  input wire logic        O_RVALID,
  input wire logic        I_POS_VALID,
  input wire logic [23:0] I_POS,
  input wire logic        O_CLOCK_INPUT_PECL_MODE,
  input wire logic        O_REFERENCE_INPUT_PECL_MODE,
  input wire logic        O_ANALOG_SUPPLY_QUIETING,
  input wire logic        O_CLOCK_SUPPLY_QUIETING,
  input wire logic [15:0] O_FULL_SCALE_CODE,
  input wire logic        O_LOW_POWER,
  input wire logic        O_HIGH_PERF
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  a_read_answer: assert property (1 |=> O_RVALID == $past(I_RD))
    else $error("read answer missing");
  a_pos_capture: assert property (I_POS_VALID ##1 (I_RD && I_ADDR == 8'h2c && !I_POS_VALID)
    |=> O_RDATA == $past(I_POS[7:0], 2)) else $error("position byte wrong");
  a_clk_pecl: assert property (I_WR && I_ADDR == 8'h2a
    |=> O_CLOCK_INPUT_PECL_MODE == $past(I_WDATA[2])) else $error("clock pecl wrong");
  a_ref_pecl: assert property (I_WR && I_ADDR == 8'h2a
    |=> O_REFERENCE_INPUT_PECL_MODE == $past(I_WDATA[1])) else $error("ref pecl wrong");
  a_analog_quiet: assert property (I_WR && I_ADDR == 8'h2b
    |=> O_ANALOG_SUPPLY_QUIETING == $past(I_WDATA[2])) else $error("analog quiet wrong");
  a_clock_quiet: assert property (I_WR && I_ADDR == 8'h2b
    |=> O_CLOCK_SUPPLY_QUIETING == $past(I_WDATA[0])) else $error("clock quiet wrong");
  a_range_low: assert property (I_WR && I_ADDR == 8'h30
    |=> O_FULL_SCALE_CODE[7:0] == $past(I_WDATA)) else $error("range low byte wrong");
  a_power_decode: assert property (I_RD && !I_WR && I_ADDR == 8'h37
    |=> O_LOW_POWER == (O_RDATA == 8'h46) && O_HIGH_PERF == (O_RDATA == 8'h4b))
    else $error("power decode wrong");
  a_reset_values: assert property ($rose(I_ARST_N)
    |-> O_FULL_SCALE_CODE == 16'ha000 && O_HIGH_PERF) else $error("reset value wrong");
endmodule

bind acrp_regs acrp_regs_properties u_props (.*);

/* File: bench/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acrp_pkg::*;
  logic I_CLK = 0, I_ARST_N = 0, I_WR = 0, I_RD = 0, I_REF_RAW = 0, I_POS_VALID = 0;
  logic [7:0]  I_ADDR = 0, I_WDATA = 0, O_RDATA, d;
  logic [23:0] I_POS = 0, p;
  logic [15:0] O_FULL_SCALE_CODE, f;
  logic [17:0] h;
  logic O_RVALID, O_REF_ALIGNED, O_CLOCK_INPUT_PECL_MODE, O_REFERENCE_INPUT_PECL_MODE;
  logic O_ANALOG_SUPPLY_QUIETING, O_CLOCK_SUPPLY_QUIETING, O_LOW_POWER, O_HIGH_PERF;
  logic O_POWER_CODE_RESERVED;
  int n_fail = 0, checked = 0, seed = 67, cyc = 0, i, j, s, inv;
  logic [7:0] ra [9] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h30, 8'h31, 8'h37, 8'h55};
  logic [7:0] rv [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h4b, 8'h00};
  always #12.5 I_CLK = ~I_CLK;
  acrp_regs dut (.*);
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end
  task results;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [23:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task step;
    @(posedge I_CLK);
    #2;
  endtask
  // Strobes stay up between back-to-back accesses; the next task overrides them.
  task wr(input logic [7:0] a, v);
    I_WR = 1;
    I_RD = 0;
    I_ADDR = a;
    I_WDATA = v;
    step;
  endtask
  task rd(input logic [7:0] a, e);
    I_RD = 1;
    I_WR = 0;
    I_ADDR = a;
    step;
    chk(O_RVALID, 1);
    chk(O_RDATA, e);
  endtask
  function automatic logic [2:0] pf(input logic [7:0] c);
    return {c == 8'h46, c == 8'h4b, c != 8'h46 && c != 8'h4b};
  endfunction
  initial begin
    repeat (4) @(posedge I_CLK);
    #2;
    I_ARST_N = 1;
    chk(O_HIGH_PERF, 1);
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 16; i++) begin
      d = $random(seed);
      wr(8'h2a, d & 8'h07);
      wr(8'h2b, (d & 8'h05) | 8'h10);
      chk(O_CLOCK_INPUT_PECL_MODE, d[2]);
      chk(O_REFERENCE_INPUT_PECL_MODE, d[1]);
      chk(O_ANALOG_SUPPLY_QUIETING, d[2]);
      chk(O_CLOCK_SUPPLY_QUIETING, d[0]);
      rd(8'h2b, (d & 8'h05) | 8'h10);
    end
    for (i = 0; i < 3; i++) begin
      f = i == 0 ? 16'hffff : i == 1 ? 16'h2000 : $random(seed) | 16'h2000;
      wr(8'h30, f[7:0]);
      wr(8'h31, f[15:8]);
      chk(O_FULL_SCALE_CODE, f);
      rd(8'h30, f[7:0]);
    end
    for (i = 0; i < 5; i++) begin
      d = i == 0 ? 8'h46 : i == 1 ? 8'h4b : ($random(seed) & 1) ? 8'h46 : 8'h4b;
      wr(8'h37, d);
      chk({O_LOW_POWER, O_HIGH_PERF, O_POWER_CODE_RESERVED}, pf(d));
      rd(8'h37, d);
    end
    p = $random(seed);
    I_POS = p;
    I_POS_VALID = 1;
    step;
    I_POS_VALID = 0;
    I_POS = ~p;
    rd(8'h2c, p[7:0]);
    wr(8'h2c, 8'hff);
    rd(8'h2d, p[15:8]);
    rd(8'h2e, p[23:16]);
    rd(8'h2c, p[7:0]);
    for (i = 0; i < 6; i++) begin
      s = i % 3 == 0 ? 0 : i % 3 == 1 ? int'(p[3:0]) : 15;
      inv = i / 3;
      wr(8'h29, 8'h80 | s[7:0]);
      wr(8'h2a, inv[7:0]);
      I_WR = 0;
      h = 0;
      for (j = 0; j < 40; j++) begin
        if (j > 20) chk(O_REF_ALIGNED, h[s + 1] ^ inv[0]);
        I_REF_RAW = $random(seed);
        h = {h[16:0], I_REF_RAW};
        step;
      end
    end
    I_ARST_N = 0;
    step;
    I_ARST_N = 1;
    chk(O_FULL_SCALE_CODE, 16'ha000);
    step;
    results();
  end
endmodule
